// File: pkg/irq_vec_pkg.sv
// package: vectors, source indices and register map of the interrupt vectoring block
package irq_vec_pkg;
    // source indices, priority order highest first among maskable sources
    localparam int unsigned SRC_PIN     = 0;
    localparam int unsigned SRC_CH0     = 1;
    localparam int unsigned SRC_CH1     = 2;
    localparam int unsigned SRC_WRAP    = 3;
    localparam int unsigned SRC_KEYPAD  = 4;
    localparam int unsigned SRC_CONV    = 5;
    localparam int unsigned NUM_SRC     = 6;

    // vector addresses (high byte address; low byte at the successor)
    localparam logic [15:0] VEC_RESET   = 16'hfffe;
    localparam logic [15:0] VEC_TRAP    = 16'hfffc;
    localparam logic [15:0] VEC_PIN     = 16'hfffa;
    localparam logic [15:0] VEC_CH0     = 16'hfff6;
    localparam logic [15:0] VEC_CH1     = 16'hfff4;
    localparam logic [15:0] VEC_WRAP    = 16'hfff2;
    localparam logic [15:0] VEC_KEYPAD  = 16'hffe0;
    localparam logic [15:0] VEC_CONV    = 16'hffde;

    // wishbone register byte offsets
    localparam logic [7:0]  OFS_STATUS  = 8'h00;
    localparam logic [7:0]  OFS_ENABLE  = 8'h04;
    localparam logic [7:0]  OFS_CLEAR   = 8'h08;
    localparam logic [7:0]  OFS_PENDING = 8'h0c;
    localparam logic [7:0]  OFS_LAST    = 8'h10;

    // status register field positions
    localparam int unsigned BIT_PIN     = 0;
    localparam int unsigned BIT_CH0     = 1;
    localparam int unsigned BIT_CH1     = 2;
    localparam int unsigned BIT_WRAP    = 3;
    localparam int unsigned BIT_KEYPAD  = 4;
    localparam int unsigned BIT_CONV    = 5;
    localparam int unsigned BIT_TRAP    = 6;

    // reset values
    localparam logic [6:0]  RST_STATUS  = 7'h00;
    localparam logic [6:0]  RST_ENABLE  = 7'h00;
    localparam logic [15:0] RST_LAST    = 16'h0000;
endpackage : irq_vec_pkg

// File: pkg/irq_req_if.sv
// interface: gated requests passed from the ranking logic to the arbiter
`timescale 1ns/1ps
interface irq_req_if #(parameter int unsigned N = 6);
    logic [N-1:0] req;
    logic         any;
    logic [2:0]   idx;
    modport src (output req, input any, input idx);
    modport arb (input req, output any, output idx);
endinterface : irq_req_if

// File: src/irq_prio_enc.sv
// module: fixed priority encoder, lowest index wins
`timescale 1ns/1ps
module irq_prio_enc #(
    parameter int unsigned N = 6
) (
    irq_req_if.arb  bus
);
    initial begin
        if (N < 1 || N > 8) begin
            $error("irq_prio_enc: N out of range");
        end
    end

    // scan from the lowest priority upward so the highest ranked one is left
    always_comb begin
        bus.any = 1'b0;
        bus.idx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (bus.req[i]) begin
                bus.any = 1'b1;
                bus.idx = 3'(i);
            end
        end
    end
endmodule : irq_prio_enc

// File: src/irq_vectoring.sv
// module: interrupt ranking, vectoring, return address and status flags
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module irq_vectoring #(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // core handshake
    input  wire logic        boundary_i,
    input  wire logic        soft_trap_instruction_i,
    input  wire logic        global_mask_flag_i,
    input  wire logic        cpu_reset_req_i,
    input  wire logic [15:0] pc_i,
    output logic             take_o,
    output logic [15:0]      vector_o,
    output logic [15:0]      stack_pc_o,
    output logic             pin_ack_o,
    // peripheral sources
    input  wire logic        pin_latch_i,
    input  wire logic        pin_request_mask_i,
    input  wire logic        timer_ch0_flag_i,
    input  wire logic        timer_ch0_enable_i,
    input  wire logic        timer_ch1_flag_i,
    input  wire logic        timer_ch1_enable_i,
    input  wire logic        timer_wrap_flag_i,
    input  wire logic        timer_wrap_enable_i,
    input  wire logic        keypad_pending_flag_i,
    input  wire logic        keypad_request_mask_i,
    input  wire logic        conversion_done_flag_i,
    input  wire logic        conversion_irq_enable_i,
    output logic             irq_pending_flag_o,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   wb_err_o,
    // event interrupt
    output logic             irq_o
);
    localparam int unsigned N = irq_vec_pkg::NUM_SRC;

    initial begin
        if (ADDR_W < 5 || ADDR_W > 8) begin
            $error("irq_vectoring: ADDR_W out of range");
        end
    end

    function automatic logic [15:0] vec_of(input logic [2:0] idx);
        case (idx)
            3'h0:    vec_of = irq_vec_pkg::VEC_PIN;
            3'h1:    vec_of = irq_vec_pkg::VEC_CH0;
            3'h2:    vec_of = irq_vec_pkg::VEC_CH1;
            3'h3:    vec_of = irq_vec_pkg::VEC_WRAP;
            3'h4:    vec_of = irq_vec_pkg::VEC_KEYPAD;
            default: vec_of = irq_vec_pkg::VEC_CONV;
        endcase
    endfunction : vec_of

    // gated source requests
    irq_req_if #(.N(N)) req_bus ();
    logic [N-1:0] pending;

    always_comb begin
        pending = '0;
        pending[irq_vec_pkg::SRC_PIN]    = pin_latch_i & ~pin_request_mask_i;
        pending[irq_vec_pkg::SRC_CH0]    = timer_ch0_flag_i & timer_ch0_enable_i;
        pending[irq_vec_pkg::SRC_CH1]    = timer_ch1_flag_i & timer_ch1_enable_i;
        pending[irq_vec_pkg::SRC_WRAP]   = timer_wrap_flag_i & timer_wrap_enable_i;
        pending[irq_vec_pkg::SRC_KEYPAD] = keypad_pending_flag_i & ~keypad_request_mask_i;
        pending[irq_vec_pkg::SRC_CONV]   = conversion_done_flag_i & conversion_irq_enable_i;
    end

    assign req_bus.req = pending;

    irq_prio_enc #(.N(N)) u_enc (
        .bus (req_bus.arb)
    );

    // raw pin latch shown whatever the pin mask says
    assign irq_pending_flag_o = pin_latch_i;

    // arbitration
    typedef enum logic [1:0] {SEL_NONE, SEL_RESET, SEL_TRAP, SEL_HW} sel_e;
    sel_e sel;

    always_comb begin
        sel = SEL_NONE;
        if (cpu_reset_req_i) begin
            sel = SEL_RESET;
        end else if (boundary_i && soft_trap_instruction_i) begin
            sel = SEL_TRAP;
        end else if (boundary_i && req_bus.any && !global_mask_flag_i) begin
            sel = SEL_HW;
        end
    end

    // vector and return address registers
    logic [15:0] vector_r;
    logic [15:0] stack_pc_r;
    logic        take_r;
    logic        pin_ack_r;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vector_r   <= irq_vec_pkg::VEC_RESET;
            stack_pc_r <= irq_vec_pkg::RST_LAST;
            take_r     <= 1'b0;
            pin_ack_r  <= 1'b0;
        end else begin
            take_r    <= (sel != SEL_NONE);
            pin_ack_r <= 1'b0;
            case (sel)
                SEL_RESET: begin
                    vector_r   <= irq_vec_pkg::VEC_RESET;
                    stack_pc_r <= pc_i;
                end
                SEL_TRAP: begin
                    vector_r   <= irq_vec_pkg::VEC_TRAP;
                    stack_pc_r <= pc_i;
                end
                SEL_HW: begin
                    vector_r   <= vec_of(req_bus.idx);
                    stack_pc_r <= pc_i - 16'h0001;
                    // a pin vector fetch acknowledges the pin latch
                    pin_ack_r  <= (req_bus.idx == 3'(irq_vec_pkg::SRC_PIN));
                end
                SEL_NONE: begin
                    vector_r   <= vector_r;
                end
                default: begin
                    vector_r   <= vector_r;
                end
            endcase
        end
    end

    assign take_o     = take_r;
    assign vector_o   = vector_r;
    assign stack_pc_o = stack_pc_r;
    assign pin_ack_o  = pin_ack_r;

    // status flags: live mirror of pending sources plus sticky event copy
    logic [6:0] live_flags;
    logic [6:0] sticky_r;
    logic [6:0] enable_r;
    logic [6:0] clear_w;

    always_comb begin
        live_flags = '0;
        live_flags[irq_vec_pkg::BIT_PIN]    = pending[irq_vec_pkg::SRC_PIN];
        live_flags[irq_vec_pkg::BIT_CH0]    = pending[irq_vec_pkg::SRC_CH0];
        live_flags[irq_vec_pkg::BIT_CH1]    = pending[irq_vec_pkg::SRC_CH1];
        live_flags[irq_vec_pkg::BIT_WRAP]   = pending[irq_vec_pkg::SRC_WRAP];
        live_flags[irq_vec_pkg::BIT_KEYPAD] = pending[irq_vec_pkg::SRC_KEYPAD];
        live_flags[irq_vec_pkg::BIT_CONV]   = pending[irq_vec_pkg::SRC_CONV];
        live_flags[irq_vec_pkg::BIT_TRAP]   = (sel == SEL_TRAP);
    end

    // wishbone decode
    logic       wb_req;
    logic       hit;
    logic [7:0] ofs;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign ofs    = 8'(wb_adr_i);
    assign hit    = (ofs == irq_vec_pkg::OFS_STATUS) || (ofs == irq_vec_pkg::OFS_ENABLE)
                 || (ofs == irq_vec_pkg::OFS_CLEAR) || (ofs == irq_vec_pkg::OFS_PENDING)
                 || (ofs == irq_vec_pkg::OFS_LAST);

    assign clear_w = (wb_req && wb_we_i && wb_sel_i[0] && ofs == irq_vec_pkg::OFS_CLEAR)
                   ? wb_dat_i[6:0] : 7'h00;

    // set wins over a clear in the same cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sticky_r <= irq_vec_pkg::RST_STATUS;
        end else begin
            sticky_r <= (sticky_r & ~clear_w) | live_flags;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_r <= irq_vec_pkg::RST_ENABLE;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && ofs == irq_vec_pkg::OFS_ENABLE) begin
            enable_r <= wb_dat_i[6:0];
        end
    end

    // one wait-free answer: ack or err the cycle after the strobe
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req & hit;
            wb_err_o <= wb_req & ~hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                case (ofs)
                    irq_vec_pkg::OFS_STATUS:  wb_dat_o <= {25'h0, sticky_r};
                    irq_vec_pkg::OFS_ENABLE:  wb_dat_o <= {25'h0, enable_r};
                    irq_vec_pkg::OFS_PENDING: wb_dat_o <= {25'h0, live_flags};
                    irq_vec_pkg::OFS_LAST:    wb_dat_o <= {16'h0, vector_r};
                    default:                  wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((sticky_r & ~clear_w) | live_flags) & enable_r);
        end
    end
endmodule : irq_vectoring

// File: verif/core_model.sv
// partner: cpu core model marking an instruction boundary every fourth cycle
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // boundary pulse
    output logic      boundary_o
);
    logic [1:0] cnt_r;
    // fixed spacing leaves the bench three quiet cycles after each take
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r      <= 2'h0;
            boundary_o <= 1'b0;
        end else begin
            cnt_r      <= cnt_r + 2'h1;
            boundary_o <= (cnt_r == 2'h3);
        end
    end
endmodule : core_model

// File: verif/irq_vectoring_assertions.sv
// checker: vector choice, return address and bus answer of irq_vectoring
`timescale 1ns/1ps
module irq_vectoring_assertions #(parameter int unsigned ADDR_W = 8) (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        boundary_i,
    input wire logic        soft_trap_instruction_i,
    input wire logic        global_mask_flag_i,
    input wire logic        cpu_reset_req_i,
    input wire logic [15:0] pc_i,
    input wire logic        take_o,
    input wire logic [15:0] vector_o,
    input wire logic [15:0] stack_pc_o,
    input wire logic        pin_ack_o,
    input wire logic        pin_latch_i,
    input wire logic        irq_pending_flag_o,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic trap_c;
    assign trap_c = boundary_i && soft_trap_instruction_i && !cpu_reset_req_i;
    a_reset_wins: assert property (cpu_reset_req_i |=> take_o && vector_o == 16'hfffe)
        else $error("reset request not served");
    a_trap_taken: assert property (trap_c |=> take_o && vector_o == 16'hfffc)
        else $error("soft trap not served");
    a_trap_pc: assert property (trap_c |=> stack_pc_o == $past(pc_i))
        else $error("soft trap stacked wrong pc");
    a_hw_pc: assert property (take_o && vector_o != 16'hfffc && vector_o != 16'hfffe
        |-> stack_pc_o == $past(pc_i) - 16'h0001) else $error("hardware take stacked wrong pc");
    a_mask_blocks: assert property (boundary_i && global_mask_flag_i
        && !soft_trap_instruction_i && !cpu_reset_req_i |=> !take_o) else $error("masked take");
    a_idle_quiet: assert property (!boundary_i && !cpu_reset_req_i |=> !take_o)
        else $error("take without boundary");
    a_pin_ack: assert property (pin_ack_o |-> take_o && vector_o == 16'hfffa)
        else $error("pin ack without pin vector");
    a_pend_mirror: assert property (irq_pending_flag_o == pin_latch_i)
        else $error("pending flag differs from pin request");
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o ^ wb_err_o) else $error("bus cycle not answered");
    c_trap_masked: cover property (trap_c && global_mask_flag_i);
    c_pin_served: cover property (pin_ack_o);
    c_conv_served: cover property (take_o && vector_o == 16'hffde);
endmodule : irq_vectoring_assertions
bind irq_vectoring irq_vectoring_assertions #(.ADDR_W(ADDR_W)) irq_vectoring_assertions_inst (.*);

// File: verif/test_irq_vectoring.sv
// testbench: priority, masking, trap, reset and registers of irq_vectoring
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module test_irq_vectoring;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        trap = 1'b0;
    logic        gmask = 1'b0;
    logic        rreq = 1'b0;
    logic [15:0] pc = 16'h1234;
    logic [5:0]  fl = 6'h00;
    logic [5:0]  en = 6'h00;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q, rdat;
    logic        qe, seen, bnd, take, pack, pend, irq, ack, err;
    logic [15:0] vec, spc;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          ord [6] = '{0, 2, 1, 3, 4, 5};
    logic [15:0] vtab [6] = '{16'hfffa, 16'hfff4, 16'hfff6, 16'hfff2, 16'hffe0, 16'hffde};
    always #2 clock_i = ~clock_i;
    core_model core_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .boundary_o(bnd));
    irq_vectoring irq_vectoring_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .boundary_i(bnd),
        .soft_trap_instruction_i(trap), .global_mask_flag_i(gmask), .cpu_reset_req_i(rreq),
        .pc_i(pc), .take_o(take), .vector_o(vec), .stack_pc_o(spc), .pin_ack_o(pack),
        .pin_latch_i(fl[0]), .pin_request_mask_i(~en[0]), .timer_ch0_flag_i(fl[1]),
        .timer_ch0_enable_i(en[1]), .timer_ch1_flag_i(fl[2]), .timer_ch1_enable_i(en[2]),
        .timer_wrap_flag_i(fl[3]), .timer_wrap_enable_i(en[3]),
        .keypad_pending_flag_i(fl[4]), .keypad_request_mask_i(~en[4]),
        .conversion_done_flag_i(fl[5]), .conversion_irq_enable_i(en[5]),
        .irq_pending_flag_o(pend), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .irq_o(irq));
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // the request stays up until the edge that samples the answer
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock_i);
            i++;
        end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
        q = rdat;
        qe = err;
        cyc <= 1'b0;
        @(posedge clock_i);
        if (q !== rdat || (ack !== 1'b1 && err !== 1'b1 && qe !== 1'b1)) begin
        end
        if (i >= 20 && ack !== 1'b1 && qe !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
    endtask : wb
    task automatic wait_take;
        int i;
        i = 0;
        do begin
            @(posedge clock_i);
            i++;
        end while (take !== 1'b1 && i < 40);
        // a take on the very last try is still a take, not a timeout
        if (take !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
    endtask : wait_take
    task automatic watch;
        seen = 1'b0;
        repeat (12) begin
            @(posedge clock_i);
            seen = seen | take;
        end
    endtask : watch
    task automatic t_regs0;
        wb(1'b0, 8'h00, 32'h0);
        `CHK("status", 32'h0, q)
        wb(1'b0, 8'h10, 32'h0);
        `CHK("last", 32'h0000fffe, q)
        wb(1'b1, 8'h04, 32'hffffffff);
        wb(1'b0, 8'h04, 32'h0);
        `CHK("enable", 32'h7f, q)
        wb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped err", 1'b1, qe)
    endtask : t_regs0
    task automatic t_mask;
        gmask <= 1'b1;
        fl <= 6'h3f;
        en <= 6'h3f;
        watch();
        `CHK("masked take", 1'b0, seen)
        gmask <= 1'b0;
        fl <= 6'h01;
        en <= 6'h00;
        watch();
        `CHK("pin masked take", 1'b0, seen)
        `CHK("pin pending", 1'b1, pend)
    endtask : t_mask
    task automatic t_trap;
        gmask <= 1'b1;
        fl <= 6'h3f;
        en <= 6'h3f;
        trap <= 1'b1;
        wait_take();
        trap <= 1'b0;
        `CHK("trap vector", 16'hfffc, vec)
        `CHK("trap pc", 16'h1234, spc)
    endtask : t_trap
    // ch0 starts disabled so ch1 must come before it
    task automatic t_prio;
        gmask <= 1'b0;
        en <= 6'h3d;
        for (int k = 0; k < 6; k++) begin
            wait_take();
            `CHK("vector", vtab[k], vec)
            `CHK("hw pc", 16'h1233, spc)
            `CHK("pin ack", (k == 0), pack)
            fl[ord[k]] <= 1'b0;
            if (k == 1) en <= 6'h3f;
        end
    endtask : t_prio
    task automatic t_regs1;
        wb(1'b0, 8'h00, 32'h0);
        `CHK("sticky", 32'h7f, q)
        wb(1'b0, 8'h10, 32'h0);
        `CHK("last vector", 32'hffde, q)
        wb(1'b1, 8'h04, 32'h0);
        @(posedge clock_i);
        `CHK("irq masked", 1'b0, irq)
        wb(1'b1, 8'h04, 32'h7f);
        @(posedge clock_i);
        `CHK("irq raised", 1'b1, irq)
        wb(1'b1, 8'h08, 32'h7f);
        @(posedge clock_i);
        `CHK("irq cleared", 1'b0, irq)
        wb(1'b0, 8'h00, 32'h0);
        `CHK("status cleared", 32'h0, q)
    endtask : t_regs1
    task automatic t_reset;
        gmask <= 1'b1;
        rreq <= 1'b1;
        wait_take();
        rreq <= 1'b0;
        `CHK("reset vector", 16'hfffe, vec)
        `CHK("reset pc", 16'h1234, spc)
        // mid-run reset must clear the stacked pc and the take pulse
        rst_n_i <= 1'b0;
        @(posedge clock_i);
        `CHK("rst stack pc", 16'h0000, spc)
        `CHK("rst take", 1'b0, take)
        `CHK("rst vector", 16'hfffe, vec)
        rst_n_i <= 1'b1;
        @(posedge clock_i);
    endtask : t_reset
    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_regs0();
        t_mask();
        t_trap();
        t_prio();
        t_regs1();
        t_reset();
        print_verdict();
    end
endmodule : test_irq_vectoring
